// ==== hdl/port_c_upper_pin_control.sv ====
// Function
// - Direction 0 plain I/O drives the pin from the latch, analog ignored.
// - Direction 1 reads pin level; digital input off while analog selected.
// - Pins 5, 6, 7 feed analog channels 17, 18, 19 when input and analog.
// - Map bits set place the relocatable functions on their default pins.
// - Map bits clear route those functions to their alternate pins.
// - Pin 5 carries serial port one data out when direction is 0.
// - Pin 6 capture/compare three: output at direction 0, capture at 1.
// - Pin 6 carries transceiver async transmit even with direction 1.
// - Sync mode: pin 6 transceiver clock, pin 7 transceiver data.
// - Pin 7 feeds transceiver receive with direction 1 and analog 0.
// - Pin 7 carries PWM three output two at direction 0; pin 6 carries output one only with map bit 2 clear.
// - Unimplemented register bits read zero: analog-select 1:0, slew 7:5, map 7, 6, 3 and 1.
// - Several enabled outputs on a pin: the higher priority one wins.
// - Peripheral outputs still drive a pin that is in analog mode.
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module port_c_upper_pin_control
  import port_c_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W/8-1:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  input wire logic [PORT_W-1:0] port_c_pin_in,
  output logic [PORT_W-1:0] port_c_pin_out,
  output logic [PORT_W-1:0] port_c_pin_oe,
  input wire logic serial1_data_out,
  input wire logic serial1_enable,
  input wire logic capcomp_three_out,
  input wire logic capcomp_three_out_en,
  output logic capcomp_three_capture,
  input wire logic pwm3_out_one,
  input wire logic pwm3_out_one_en,
  input wire logic pwm3_out_two,
  input wire logic pwm3_out_two_en,
  input wire logic uart1_enable,
  input wire logic uart1_sync_mode,
  input wire logic uart1_transmit,
  input wire logic uart1_transmit_en,
  input wire logic uart1_sync_clock_out,
  input wire logic uart1_sync_clock_oe,
  output logic uart1_sync_clock_in,
  input wire logic uart1_sync_data_out,
  input wire logic uart1_sync_data_oe,
  output logic uart1_sync_data_in,
  output logic uart1_receive,
  output logic [2:0] analog_connect,
  output logic pwm2b_default_pin,
  output logic timer3_clk_default_pin,
  output logic capcomp3_default_pin,
  output logic capcomp2_default_pin,
  output logic [SLEW_FIELD_W-1:0] slew_rate_limit
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [REG_W-1:0] analog_select_c;
    logic [REG_W-1:0] output_latch_c;
    logic [REG_W-1:0] slew_register;
    logic [REG_W-1:0] direction_c;
    logic [REG_W-1:0] pin_map;
    logic aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [REG_W-1:0] w_data;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [PORT_W-1:0] pin_out;
    logic [PORT_W-1:0] pin_oe;
    logic capture;
    logic sync_clock_in;
    logic sync_data_in;
    logic receive;
    logic [2:0] analog_connect;
    logic [3:0] map_default;
    logic [SLEW_FIELD_W-1:0] slew_limit;
  } state_s;

  localparam state_s STATE_RESET = '{
    analog_select_c: ANALOG_SELECT_RESET,
    output_latch_c: OUTPUT_LATCH_RESET,
    slew_register: SLEW_RESET,
    direction_c: DIRECTION_RESET,
    pin_map: PIN_MAP_RESET,
    aw_full: 1'b0,
    aw_addr: '0,
    w_full: 1'b0,
    w_data: '0,
    w_lane0: 1'b0,
    awready: 1'b1,
    wready: 1'b1,
    bvalid: 1'b0,
    bresp: RESP_OKAY,
    arready: 1'b1,
    rvalid: 1'b0,
    rdata: '0,
    rresp: RESP_OKAY,
    pin_out: '0,
    pin_oe: '0,
    capture: 1'b0,
    sync_clock_in: 1'b0,
    sync_data_in: 1'b0,
    receive: 1'b1,
    analog_connect: 3'h0,
    map_default: 4'h0,
    slew_limit: '0
  };

  state_s s;
  state_s next_s;

  logic [PORT_W-1:0] pin_stable;
  logic [PORT_W-1:0] digital_in;
  logic [PORT_W-1:0] analog_eff;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic capcomp3_alt;

  // ****************************************************************
  // Pin input synchroniser
  // ****************************************************************
  pin_input_sync #(.WIDTH(PORT_W)) i_pin_input_sync (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .pin_in(port_c_pin_in),
    .pin_stable(pin_stable)
  );

  // ****************************************************************
  // Register read decode
  // ****************************************************************
  function automatic logic [DATA_W:0] read_reg(
    input logic [ADDR_W-1:0] addr,
    input state_s st,
    input logic [PORT_W-1:0] din
  );
    logic [REG_W-1:0] value;
    logic hit;
    value = '0;
    hit = 1'b1;
    case (addr[ADDR_W-1:2])
      ANALOG_SELECT_ADDR[ADDR_W-1:2]:
        value = st.analog_select_c & ANALOG_SELECT_MASK;
      OUTPUT_LATCH_ADDR[ADDR_W-1:2]:
        value = st.output_latch_c;
      PIN_DATA_ADDR[ADDR_W-1:2]:
        value = din;
      SLEW_ADDR[ADDR_W-1:2]:
        value = st.slew_register & SLEW_MASK;
      DIRECTION_ADDR[ADDR_W-1:2]:
        value = st.direction_c;
      PIN_MAP_ADDR[ADDR_W-1:2]:
        value = st.pin_map & PIN_MAP_MASK;
      default:
        hit = 1'b0;
    endcase
    // Upper 24 data bits are always zero
    return {hit, {(DATA_W-REG_W){1'b0}}, value};
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [DATA_W:0] rd;
    logic [REG_W-1:0] wv;
    logic wr_hit;
    rd = '0;
    wv = '0;
    wr_hit = 1'b0;
    next_s = s;

    analog_eff = s.analog_select_c & ANALOG_SELECT_MASK;
    // Digital input buffer is gated off on analog pins
    digital_in = pin_stable & ~analog_eff;
    capcomp3_alt = !s.pin_map[CAPCOMP3_MAP_BIT];

    // Write channel: address and data may arrive in either order
    aw_fire = awvalid && s.awready;
    w_fire = wvalid && s.wready;
    if (aw_fire) begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (w_fire) begin
      next_s.w_full = 1'b1;
      next_s.w_data = wdata[REG_W-1:0];
      next_s.w_lane0 = wstrb[0];
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (next_s.aw_full && next_s.w_full && !next_s.bvalid) begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      wr_hit = 1'b1;
      wv = next_s.w_data;
      // Only byte lane 0 carries register data; other lanes are ignored
      case (next_s.aw_addr[ADDR_W-1:2])
        ANALOG_SELECT_ADDR[ADDR_W-1:2]: begin
          if (next_s.w_lane0) begin
            next_s.analog_select_c = wv & ANALOG_SELECT_MASK;
          end
        end
        OUTPUT_LATCH_ADDR[ADDR_W-1:2], PIN_DATA_ADDR[ADDR_W-1:2]: begin
          // Writing pin data lands in the latch, as on any port
          if (next_s.w_lane0) begin
            next_s.output_latch_c = wv;
          end
        end
        SLEW_ADDR[ADDR_W-1:2]: begin
          if (next_s.w_lane0) begin
            next_s.slew_register = wv & SLEW_MASK;
          end
        end
        DIRECTION_ADDR[ADDR_W-1:2]: begin
          if (next_s.w_lane0) begin
            next_s.direction_c = wv;
          end
        end
        PIN_MAP_ADDR[ADDR_W-1:2]: begin
          if (next_s.w_lane0) begin
            next_s.pin_map = wv & PIN_MAP_MASK;
          end
        end
        default: begin
          wr_hit = 1'b0;
        end
      endcase
      next_s.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    next_s.awready = !next_s.aw_full && !next_s.bvalid;
    next_s.wready = !next_s.w_full && !next_s.bvalid;

    // Read channel: one read in flight, data captured at the handshake
    ar_fire = arvalid && s.arready;
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (ar_fire) begin
      rd = read_reg(araddr, s, digital_in);
      next_s.rvalid = 1'b1;
      next_s.rdata = rd[DATA_W-1:0];
      next_s.rresp = rd[DATA_W] ? RESP_OKAY : RESP_SLVERR;
    end
    next_s.arready = !next_s.rvalid;

    // Plain port I/O on every pin; upper pins are overridden below
    next_s.pin_out = s.output_latch_c;
    next_s.pin_oe = ~s.direction_c;

    // Pin 5: serial data out over the latch; analog mode does not block
    if (serial1_enable && !s.direction_c[PIN5]) begin
      next_s.pin_out[PIN5] = serial1_data_out;
    end

    // Pin 6, highest priority first: sync clock, async transmit,
    // PWM three output one, compare three output, latch
    if (uart1_enable && uart1_sync_mode) begin
      next_s.pin_out[PIN6] = uart1_sync_clock_out;
      next_s.pin_oe[PIN6] = uart1_sync_clock_oe;
    end else if (uart1_enable && uart1_transmit_en) begin
      // Transmitter owns the driver whatever the direction bit says
      next_s.pin_out[PIN6] = uart1_transmit;
      next_s.pin_oe[PIN6] = 1'b1;
    end else if (capcomp3_alt && pwm3_out_one_en
                 && !s.direction_c[PIN6]) begin
      next_s.pin_out[PIN6] = pwm3_out_one;
    end else if (capcomp3_alt && capcomp_three_out_en
                 && !s.direction_c[PIN6]) begin
      next_s.pin_out[PIN6] = capcomp_three_out;
    end

    // Pin 7, highest priority first: sync data, PWM three two, latch
    if (uart1_enable && uart1_sync_mode) begin
      next_s.pin_out[PIN7] = uart1_sync_data_out;
      next_s.pin_oe[PIN7] = uart1_sync_data_oe;
    end else if (pwm3_out_two_en && !s.direction_c[PIN7]) begin
      next_s.pin_out[PIN7] = pwm3_out_two;
    end

    // Peripheral inputs; an analog pin reads as 0, receive idles high
    next_s.capture = capcomp3_alt && s.direction_c[PIN6]
                     && digital_in[PIN6];
    next_s.sync_clock_in = digital_in[PIN6];
    next_s.sync_data_in = digital_in[PIN7];
    next_s.receive = (s.direction_c[PIN7] && !analog_eff[PIN7])
                     ? pin_stable[PIN7] : 1'b1;

    // Analog channels 17, 18 and 19 connect only on input analog pins
    next_s.analog_connect = s.direction_c[PIN7:PIN5]
                            & analog_eff[PIN7:PIN5];

    // Relocation: a set bit keeps the function on its default pin
    next_s.map_default = {s.pin_map[PWM2B_MAP_BIT],
                          s.pin_map[TIMER3_CLK_MAP_BIT],
                          s.pin_map[CAPCOMP3_MAP_BIT],
                          s.pin_map[CAPCOMP2_MAP_BIT]};
    next_s.slew_limit = s.slew_register[SLEW_FIELD_W-1:0];
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= STATE_RESET;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign port_c_pin_out = s.pin_out;
  assign port_c_pin_oe = s.pin_oe;
  assign capcomp_three_capture = s.capture;
  assign uart1_sync_clock_in = s.sync_clock_in;
  assign uart1_sync_data_in = s.sync_data_in;
  assign uart1_receive = s.receive;
  assign analog_connect = s.analog_connect;
  assign {pwm2b_default_pin, timer3_clk_default_pin, capcomp3_default_pin,
          capcomp2_default_pin} = s.map_default;
  assign slew_rate_limit = s.slew_limit;

endmodule

`default_nettype wire

// ==== pkg/port_c_pkg.sv ====
package port_c_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int PORT_W = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [ADDR_W-1:0] ANALOG_SELECT_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] OUTPUT_LATCH_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] PIN_DATA_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] SLEW_ADDR = 8'h0c;
  localparam logic [ADDR_W-1:0] DIRECTION_ADDR = 8'h10;
  localparam logic [ADDR_W-1:0] PIN_MAP_ADDR = 8'h14;

  // ****************************************************************
  // Implemented bits and reset values
  // ****************************************************************
  localparam logic [REG_W-1:0] ANALOG_SELECT_MASK = 8'hfc;
  localparam logic [REG_W-1:0] SLEW_MASK = 8'h1f;
  localparam logic [REG_W-1:0] PIN_MAP_MASK = 8'h35;

  localparam logic [REG_W-1:0] ANALOG_SELECT_RESET = 8'hfc;
  localparam logic [REG_W-1:0] OUTPUT_LATCH_RESET = 8'h00;
  localparam logic [REG_W-1:0] SLEW_RESET = 8'h1f;
  localparam logic [REG_W-1:0] DIRECTION_RESET = 8'hff;
  localparam logic [REG_W-1:0] PIN_MAP_RESET = 8'h35;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PWM2B_MAP_BIT = 5;
  localparam int TIMER3_CLK_MAP_BIT = 4;
  localparam int CAPCOMP3_MAP_BIT = 2;
  localparam int CAPCOMP2_MAP_BIT = 0;
  localparam int SLEW_FIELD_W = 5;

  localparam int PIN5 = 5;
  localparam int PIN6 = 6;
  localparam int PIN7 = 7;

endpackage

// ==== hdl/pin_input_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module pin_input_sync
  import port_c_pkg::*;
#(
  parameter int WIDTH = PORT_W
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_stable
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] stable;
  } sync_s;

  sync_s s;
  sync_s next_s;

  // A bit only moves once stages two and three agree; stage one is
  // left to the next flop alone so metastability cannot leak.
  always_comb begin
    next_s = s;
    next_s.stage1 = pin_in;
    next_s.stage2 = s.stage1;
    next_s.stage3 = s.stage2;
    for (int i = 0; i < WIDTH; i++) begin
      if (s.stage2[i] == s.stage3[i]) begin
        next_s.stable[i] = s.stage3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign pin_stable = s.stable;

endmodule

`default_nettype wire

// ==== tb/pad_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ******
// Board side of the port pads
// ******
module pad_model (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] board,
  output logic [7:0] pin_in
);
  // A driven pad reads back its own drive, a released one the board level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : board[i];
    end
  end
endmodule
`default_nettype wire

// ==== tb/port_c_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module port_c_chk
  import port_c_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [PORT_W-1:0] port_c_pin_out,
  input wire logic [PORT_W-1:0] port_c_pin_oe,
  input wire logic pwm3_out_two,
  input wire logic pwm3_out_two_en,
  input wire logic uart1_enable,
  input wire logic uart1_sync_mode,
  input wire logic uart1_transmit,
  input wire logic uart1_transmit_en,
  input wire logic uart1_sync_clock_oe,
  input wire logic uart1_sync_data_oe,
  input wire logic [2:0] analog_connect
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_wr_take;
    ce && awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_take;
    ce && arvalid && arready;
  endsequence
  a_write_answer: assert property (
    s_wr_take |=> bvalid && !awready && !wready)
    else $error("write response missing");
  a_write_close: assert property (
    ce && bvalid && bready |=> !bvalid && awready && wready)
    else $error("write channel not reopened");
  a_read_answer: assert property (
    s_rd_take |=> rvalid && !arready)
    else $error("read response missing");
  a_rdata_upper: assert property (
    rvalid |-> rdata[DATA_W-1:8] == '0)
    else $error("read data above bit 7 not zero");
  a_tx_override: assert property (
    ce && uart1_enable && !uart1_sync_mode && uart1_transmit_en
    |=> port_c_pin_oe[6] && port_c_pin_out[6] == $past(uart1_transmit))
    else $error("transmit does not own pin 6");
  a_sync_enables: assert property (
    ce && uart1_enable && uart1_sync_mode
    |=> port_c_pin_oe[6] == $past(uart1_sync_clock_oe)
    && port_c_pin_oe[7] == $past(uart1_sync_data_oe))
    else $error("sync enables not on pins 6 and 7");
  a_pwm_two: assert property (
    ce && pwm3_out_two_en && !(uart1_enable && uart1_sync_mode)
    |=> !port_c_pin_oe[7] || port_c_pin_out[7] == $past(pwm3_out_two))
    else $error("pwm output two not on pin 7");
  a_analog_off: assert property (
    analog_connect[0] |-> !port_c_pin_oe[5])
    else $error("pin 5 driven while analog connected");
endmodule
bind port_c_upper_pin_control port_c_chk i_port_c_chk (
  .clk, .reset_n, .ce, .awvalid, .awready, .wvalid, .wready, .bvalid,
  .bready, .arvalid, .arready, .rvalid, .rdata, .port_c_pin_out,
  .port_c_pin_oe, .pwm3_out_two, .pwm3_out_two_en, .uart1_enable,
  .uart1_sync_mode, .uart1_transmit, .uart1_transmit_en,
  .uart1_sync_clock_oe, .uart1_sync_data_oe, .analog_connect);
`default_nettype wire

// ==== tb/port_c_upper_pin_control_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module port_c_upper_pin_control_bench
  import port_c_pkg::*;
;
  logic clk = 0, reset_n = 0, ce = 1;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [3:0] wstrb = 4'h1;
  logic [PORT_W-1:0] board = '0;
  logic [15:0] pv = '0;
  wire awready, wready, bvalid, arready, rvalid, cap, clk_in, dat_in, rx;
  wire [DATA_W-1:0] rdata;
  wire [1:0] bresp, rresp;
  wire [PORT_W-1:0] pin_in, pin_out, pin_oe;
  wire [2:0] acon;
  wire [3:0] map_pins;
  wire [SLEW_FIELD_W-1:0] slew;
  int error_cnt = 0;
  int compares = 0;
  always #20 clk = ~clk;
  port_c_upper_pin_control i_port_c_upper_pin_control (
    .clk, .reset_n, .ce, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp, .port_c_pin_in(pin_in),
    .port_c_pin_out(pin_out), .port_c_pin_oe(pin_oe),
    .serial1_data_out(pv[0]), .serial1_enable(pv[1]),
    .capcomp_three_out(pv[2]), .capcomp_three_out_en(pv[3]),
    .capcomp_three_capture(cap), .pwm3_out_one(pv[4]),
    .pwm3_out_one_en(pv[5]), .pwm3_out_two(pv[6]), .pwm3_out_two_en(pv[7]),
    .uart1_enable(pv[8]), .uart1_sync_mode(pv[9]), .uart1_transmit(pv[10]),
    .uart1_transmit_en(pv[11]), .uart1_sync_clock_out(pv[12]),
    .uart1_sync_clock_oe(pv[13]), .uart1_sync_clock_in(clk_in),
    .uart1_sync_data_out(pv[14]), .uart1_sync_data_oe(pv[15]),
    .uart1_sync_data_in(dat_in), .uart1_receive(rx), .analog_connect(acon),
    .pwm2b_default_pin(map_pins[3]), .timer3_clk_default_pin(map_pins[2]),
    .capcomp3_default_pin(map_pins[1]), .capcomp2_default_pin(map_pins[0]),
    .slew_rate_limit(slew));
  pad_model i_pad_model (.pin_out, .pin_oe, .board, .pin_in);
  // ******
  // Bus cycles and comparison
  // ******
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Reads pre-edge values, so what is seen settled after the previous edge
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
      output logic [1:0] r);
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk("bresp", RESP_OKAY, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk("rdata", {24'h00_0000, exp}, d);
  endtask
  // ******
  // Scenarios
  // ******
  task automatic t_reset();
    logic [7:0] adr [7] = '{ANALOG_SELECT_ADDR, OUTPUT_LATCH_ADDR,
      PIN_DATA_ADDR, SLEW_ADDR, DIRECTION_ADDR, PIN_MAP_ADDR, 8'h18};
    logic [7:0] exp [7] = '{ANALOG_SELECT_RESET, OUTPUT_LATCH_RESET, 8'h00,
      SLEW_RESET, DIRECTION_RESET, PIN_MAP_RESET, 8'h00};
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 7; i++) begin
      rd(adr[i], d, r);
      chk("reset value", {24'h00_0000, exp[i]}, d);
      chk("rresp", (i == 6) ? RESP_SLVERR : RESP_OKAY, r);
    end
    chk("pin oe", 8'h00, pin_oe);
    chk("map pins", 4'hf, map_pins);
    chk("slew", SLEW_RESET[SLEW_FIELD_W-1:0], slew);
  endtask
  task automatic t_mask();
    logic [7:0] adr [5] = '{ANALOG_SELECT_ADDR, OUTPUT_LATCH_ADDR,
      SLEW_ADDR, DIRECTION_ADDR, PIN_MAP_ADDR};
    logic [7:0] msk [5] = '{8'hfc, 8'hff, SLEW_MASK, 8'hff, PIN_MAP_MASK};
    logic [1:0] r;
    for (int i = 0; i < 5; i++) begin
      w(adr[i], 8'hff);
      rchk(adr[i], msk[i]);
    end
    wr(8'h18, 8'h00, r);
    chk("bresp unmapped", RESP_SLVERR, r);
    wstrb <= 4'h0;
    w(SLEW_ADDR, 8'h00);
    wstrb <= 4'h1;
    rchk(SLEW_ADDR, SLEW_MASK);
  endtask
  task automatic t_latch();
    w(DIRECTION_ADDR, 8'h00);
    w(OUTPUT_LATCH_ADDR, 8'ha5);
    settle(2);
    chk("pin oe", 8'hff, pin_oe);
    chk("pin out", 8'ha5, pin_out);
    w(PIN_DATA_ADDR, 8'h3c);
    settle(2);
    chk("pin out", 8'h3c, pin_out);
  endtask
  task automatic t_read();
    w(DIRECTION_ADDR, 8'hff);
    w(ANALOG_SELECT_ADDR, 8'h00);
    board <= 8'h5a;
    settle(8);
    rchk(PIN_DATA_ADDR, 8'h5a);
    w(ANALOG_SELECT_ADDR, 8'hfc);
    settle(8);
    rchk(PIN_DATA_ADDR, 8'h02);
  endtask
  task automatic t_analog();
    chk("analog", 3'h7, acon);
    w(ANALOG_SELECT_ADDR, 8'hdc);
    w(DIRECTION_ADDR, 8'h7f);
    settle(2);
    chk("analog", 3'h2, acon);
    w(ANALOG_SELECT_ADDR, 8'hfc);
  endtask
  task automatic t_map();
    w(PIN_MAP_ADDR, 8'h00);
    settle(2);
    chk("map pins", 4'h0, map_pins);
    w(PIN_MAP_ADDR, 8'h35);
    settle(2);
    chk("map pins", 4'hf, map_pins);
    w(PIN_MAP_ADDR, 8'h00);
  endtask
  // Analog select stays set for the drive checks, so each also shows analog mode; the input checks clear it until the rx analog check sets bit 7
  task automatic t_periph();
    w(DIRECTION_ADDR, 8'h00);
    w(OUTPUT_LATCH_ADDR, 8'h00);
    pv <= 16'h00fb;
    settle(2);
    chk("pins 7:5", 3'h7, pin_out[7:5]);
    ce <= 1'b0;
    pv <= 16'h000c;
    settle(2);
    chk("frozen pins", 3'h7, pin_out[7:5]);
    ce <= 1'b1;
    settle(2);
    chk("pins 7:5", 3'h2, pin_out[7:5]);
    w(DIRECTION_ADDR, 8'hff);
    pv <= 16'h0d00;
    settle(2);
    chk("pin 6 tx", 2'h3, {pin_oe[6], pin_out[6]});
    pv <= 16'hb300;
    settle(2);
    chk("sync drive", 4'hd, {pin_oe[7:6], pin_out[7:6]});
    w(ANALOG_SELECT_ADDR, 8'h00);
    pv <= 16'h0300;
    board <= 8'hc0;
    settle(8);
    chk("sync in", 2'h3, {clk_in, dat_in});
    pv <= 16'h0000;
    board <= 8'h40;
    settle(8);
    chk("capture rx", 4'ha, {cap, rx, clk_in, dat_in});
    w(ANALOG_SELECT_ADDR, 8'h80);
    settle(8);
    chk("rx analog", 1'b1, rx);
  endtask
  task automatic summarize();
    $display("mismatches %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_mask();
    t_latch();
    t_read();
    t_analog();
    t_map();
    t_periph();
    summarize();
  end
  // The whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
